// ==== dac_loader_pkg.sv ====
/*
 * Shared constants and carrier types of the serial converter word loader.
 * Assumes the user writes every name as dac_loader_pkg::name.
 */
package dac_loader_pkg;

    // Width of one converter word
    localparam int WORD_BITS = 10;
    // Bit counter width and terminal value (the tenth edge)
    localparam int CNT_BITS = 4;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_BITS-1:0] CNT_LAST = 4'h9;

    // Reset value of the output register: mid scale in two's complement
    localparam logic [WORD_BITS-1:0] CODE_RESET = 10'h000;
    // Sign bit position and the flip that turns the code into a level index
    localparam int SIGN_BIT = WORD_BITS - 1;
    localparam logic [WORD_BITS-1:0] SIGN_FLIP = 10'h200;

    // Core clock rate and worst-case output settling after an update
    localparam int CORE_CLK_KHZ = 40000;
    localparam int SETTLE_NS = 2500;
    // Least wait, rounded up to whole core cycles
    localparam int SETTLE_CYC = (SETTLE_NS * CORE_CLK_KHZ + 999999) / 1000000;
    localparam int SETTLE_BITS = 8;
    localparam logic [SETTLE_BITS-1:0] SETTLE_LOAD = SETTLE_BITS'(SETTLE_CYC - 1);
    localparam logic [SETTLE_BITS-1:0] SETTLE_ZERO = 8'h00;
    localparam logic [SETTLE_BITS-1:0] SETTLE_STEP = 8'h01;

    // Drive bundle towards the analog converter core
    typedef struct packed {
        logic enable;                   // Converter and buffer powered
        logic [WORD_BITS-1:0] level;    // Unsigned step, 0 is zero scale
    } dac_drive_t;

    // Status bundle seen by the rest of the chip
    typedef struct packed {
        logic asleep;                   // Low-power state entered
        logic settling;                 // Output still moving toward new code
    } dac_status_t;

    // Power states of the analog side
    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_WAKE
    } pwr_state_t;

endpackage

// ==== host_link_model.sv ====
/*
 * Host side of the three-wire serial link: select, shift clock and data.
 * Assumes the caller spaces frames; shift clock stands low between frames.
 */
`timescale 1ns/1ps
module host_link_model (
    output logic shift_clk,
    output logic load_select_n,
    output logic serial_data
);
    // Idle link: deselected, clock still
    initial begin
        shift_clk = 1'b0;
        load_select_n = 1'b1;
        serial_data = 1'b0;
    end

    // Sends the first n bits of a frame, 30 ns clock, data moved on the low phase
    task automatic send(input logic [19:0] bits, input int n);
        load_select_n = 1'b0;
        #50;
        for (int i = 0; i < n; i++) begin
            serial_data = bits[i];
            #15 shift_clk = 1'b1;
            #15 shift_clk = 1'b0;
        end
        #60 load_select_n = 1'b1;
        // Released data line shows no stale value
        serial_data = ~serial_data;
        #60;
    endtask
endmodule // host_link_model

// ==== level_sync.sv ====
/*
 * Two-flop synchroniser for a single level crossing into a clock domain.
 * Assumes the input is a level held for at least two destination cycles.
 */
`timescale 1ns/1ps
module level_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    // First stage, read only by the second stage
    logic meta_q;
    // Second stage, safe to use
    logic sync_q;

    // Two flip-flops in series, cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // level_sync

// ==== serial_dac_word_loader.sv ====
/*
 * Digital front end of a 10-bit serial converter: a three-wire serial port
 * shifts in a word, loads the output register and drives the converter core.
 * Assumes shift_clk is the host's shift clock, stopped outside frames, and
 * that core_clk is free running and unrelated to it.
 */
//
// Summary of operation
// R1 - Select low, then sample data on rising edges
// R2 - Word arrives least significant bit first
// R3 - Tenth edge loads word and updates output
// R4 - Edges after the tenth are ignored
// R5 - New word needs select high then low
// R6 - Code is two's complement around mid scale
// R7 - Power-down high sleeps, low runs normally
// R8 - Early select release drops partial word
`timescale 1ns/1ps
module serial_dac_word_loader (
    // Core clock, free running
    input wire logic core_clk,
    // Chip reset, active low, asynchronous
    input wire logic rst_n,
    // Host shift clock, clock of the link logic
    input wire logic shift_clk,
    // Chip select from the host, active low
    input wire logic load_select_n,
    // Serial data from the host
    input wire logic serial_data,
    // Power-down request, high sleeps
    input wire logic power_down,
    // Code held in the output register
    output logic [dac_loader_pkg::WORD_BITS-1:0] output_code,
    // Drive towards the analog output stage
    output dac_loader_pkg::dac_drive_t analog_output,
    // Reference stage enable
    output logic reference_output,
    // One core cycle per new word taken
    output logic update_pulse,
    // Sleep and settling status
    output dac_loader_pkg::dac_status_t status
);

    // Converts a two's-complement code into an unsigned step index
    function automatic logic [dac_loader_pkg::WORD_BITS-1:0] code_to_level(
        input logic [dac_loader_pkg::WORD_BITS-1:0] code
    );
        code_to_level = code ^ dac_loader_pkg::SIGN_FLIP;
    endfunction

    // Reset release, core domain
    logic rst_meta_q;
    // Synchronised reset, used everywhere else
    logic rst_q;

    // Assert at once, release after two core edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end

    // ---- Link domain, clocked by shift_clk ----

    // Frame reset: held while select is high or the chip is in reset
    logic frame_rst_n;
    // Bits taken so far in this frame
    logic [dac_loader_pkg::CNT_BITS-1:0] bit_cnt_q;
    // Partial word, filled from the top
    logic [dac_loader_pkg::WORD_BITS-1:0] shift_q;
    // Word complete, rest of frame ignored
    logic frame_done_q;
    // Completed word handed to the core domain
    logic [dac_loader_pkg::WORD_BITS-1:0] word_hold_q;
    // Toggles once per completed word
    logic word_tgl_q;
    // Tenth edge of this frame
    logic last_edge;

    // Select high clears the frame, low opens it
    assign frame_rst_n = rst_q & ~load_select_n; // [R1] [R5] [R8]

    // The edge that completes the word
    assign last_edge = !frame_done_q && (bit_cnt_q == dac_loader_pkg::CNT_LAST); // [R3]

    // Bit counter, cleared when select goes high
    always_ff @(posedge shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            // Partial count dropped
            bit_cnt_q <= dac_loader_pkg::CNT_ZERO; // [R8]
        end else if (frame_done_q) begin
            // Word already taken, hold
            bit_cnt_q <= dac_loader_pkg::CNT_ZERO; // [R4]
        end else if (last_edge) begin
            // Count restarts after the tenth bit
            bit_cnt_q <= dac_loader_pkg::CNT_ZERO; // [R3]
        end else begin
            // One bit per rising edge
            bit_cnt_q <= bit_cnt_q + dac_loader_pkg::CNT_ONE; // [R1]
        end
    end

    // Shift register, new bit enters at the top so the first bit lands lowest
    always_ff @(posedge shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            // Partial word discarded
            shift_q <= dac_loader_pkg::CODE_RESET; // [R8]
        end else if (!frame_done_q) begin
            // Least significant bit first
            shift_q <= {serial_data, shift_q[dac_loader_pkg::WORD_BITS-1:1]}; // [R2]
        end
    end

    // Done flag, blocks the rest of the frame until select rises
    always_ff @(posedge shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            // Armed again by select high
            frame_done_q <= 1'b0; // [R5]
        end else if (last_edge) begin
            // Further edges and data ignored
            frame_done_q <= 1'b1; // [R4]
        end
    end

    // Hand-off word and toggle survive select release; only chip reset clears them
    always_ff @(posedge shift_clk or negedge rst_q) begin
        if (!rst_q) begin
            word_hold_q <= dac_loader_pkg::CODE_RESET;
            word_tgl_q <= 1'b0;
        end else if (last_edge) begin
            // Complete word, tenth bit on top
            word_hold_q <= {serial_data, shift_q[dac_loader_pkg::WORD_BITS-1:1]}; // [R2] [R3]
            // Announce the new word to the core side
            word_tgl_q <= ~word_tgl_q; // [R3]
        end
    end

    // ---- Core domain ----

    // Toggle after two flops
    logic word_tgl_sync;
    // Previous synchronised toggle, for change detection
    logic word_tgl_seen_q;
    // A new word waits in word_hold_q
    logic word_new;
    // Power-down after two flops
    logic sleep_req_sync;

    // Word toggle crossing
    level_sync u_word_sync (
        .clk(core_clk),
        .rst_n(rst_q),
        .async_in(word_tgl_q),
        .sync_out(word_tgl_sync)
    );

    // Power-down pin crossing
    level_sync u_sleep_sync (
        .clk(core_clk),
        .rst_n(rst_q),
        .async_in(power_down),
        .sync_out(sleep_req_sync)
    );

    // Remember the last toggle value acted on
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            word_tgl_seen_q <= 1'b0;
        end else begin
            word_tgl_seen_q <= word_tgl_sync;
        end
    end

    // Toggle change marks a word ready; hold data has been stable for two cycles
    assign word_new = word_tgl_sync ^ word_tgl_seen_q; // [R3]

    // Output register
    logic [dac_loader_pkg::WORD_BITS-1:0] code_q;
    // Update strobe register
    logic update_q;

    // Load the output register once per word
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            // Mid scale after reset
            code_q <= dac_loader_pkg::CODE_RESET;
        end else if (word_new) begin
            // Latch the new code
            code_q <= word_hold_q; // [R3]
        end
    end

    // One-cycle strobe per taken word
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            update_q <= 1'b0;
        end else begin
            update_q <= word_new;
        end
    end

    // Power state
    dac_loader_pkg::pwr_state_t pwr_q;
    dac_loader_pkg::pwr_state_t pwr_d;
    // Settle countdown after an update or a wake
    logic [dac_loader_pkg::SETTLE_BITS-1:0] settle_q;
    // Countdown has reached zero
    logic settle_zero;

    assign settle_zero = (settle_q == dac_loader_pkg::SETTLE_ZERO);

    // Next power state
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            dac_loader_pkg::PWR_ACTIVE: begin
                // Power-down high enters sleep
                if (sleep_req_sync) begin
                    pwr_d = dac_loader_pkg::PWR_SLEEP; // [R7]
                end
            end
            dac_loader_pkg::PWR_SLEEP: begin
                // Power-down low wakes the converter
                if (!sleep_req_sync) begin
                    pwr_d = dac_loader_pkg::PWR_WAKE; // [R7]
                end
            end
            dac_loader_pkg::PWR_WAKE: begin
                // Back to sleep at once, or running after one cycle
                if (sleep_req_sync) begin
                    pwr_d = dac_loader_pkg::PWR_SLEEP; // [R7]
                end else begin
                    pwr_d = dac_loader_pkg::PWR_ACTIVE; // [R7]
                end
            end
            default: begin
                // Unused state code, recover to running
                pwr_d = dac_loader_pkg::PWR_ACTIVE;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            pwr_q <= dac_loader_pkg::PWR_ACTIVE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // Settle timer: cleared while asleep, else reloads on a new code or on wake and counts down otherwise
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            settle_q <= dac_loader_pkg::SETTLE_ZERO;
        end else if (pwr_q == dac_loader_pkg::PWR_SLEEP) begin
            // No settling while asleep
            settle_q <= dac_loader_pkg::SETTLE_ZERO;
        end else if (word_new || pwr_q == dac_loader_pkg::PWR_WAKE) begin
            // Output starts moving
            settle_q <= dac_loader_pkg::SETTLE_LOAD;
        end else if (!settle_zero) begin
            settle_q <= settle_q - dac_loader_pkg::SETTLE_STEP;
        end
    end

    // Drive and status registers
    dac_loader_pkg::dac_drive_t drive_q;
    dac_loader_pkg::dac_status_t status_q;
    logic ref_en_q;

    // Converter drive follows the output register and the power state
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            drive_q.enable <= 1'b0;
            drive_q.level <= code_to_level(dac_loader_pkg::CODE_RESET);
            ref_en_q <= 1'b0;
        end else begin
            // Analog side powered only when not sleeping
            drive_q.enable <= (pwr_d != dac_loader_pkg::PWR_SLEEP); // [R7]
            ref_en_q <= (pwr_d != dac_loader_pkg::PWR_SLEEP); // [R7]
            // Two's-complement code mapped to a step above zero scale
            drive_q.level <= code_to_level(word_new ? word_hold_q : code_q); // [R6]
        end
    end

    // Status flags
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            status_q.asleep <= 1'b0;
            status_q.settling <= 1'b0;
        end else begin
            status_q.asleep <= (pwr_d == dac_loader_pkg::PWR_SLEEP); // [R7]
            status_q.settling <= word_new || (pwr_q == dac_loader_pkg::PWR_WAKE) ||
                (pwr_q != dac_loader_pkg::PWR_SLEEP && settle_q > dac_loader_pkg::SETTLE_STEP);
        end
    end

    // Outputs, all from registers
    assign output_code = code_q;
    assign analog_output = drive_q;
    assign reference_output = ref_en_q;
    assign update_pulse = update_q;
    assign status = status_q;

endmodule // serial_dac_word_loader

// ==== serial_dac_word_loader_props.sv ====
/*
 * Checker of the serial converter word loader, watching its top ports only.
 * Assumes the design package is compiled first; bound to the design below.
 */
`timescale 1ns/1ps
module serial_dac_word_loader_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load_select_n,
    input wire logic power_down,
    input wire logic [dac_loader_pkg::WORD_BITS-1:0] output_code,
    input wire dac_loader_pkg::dac_drive_t analog_output,
    input wire logic reference_output,
    input wire logic update_pulse,
    input wire dac_loader_pkg::dac_status_t status
);
    // One clock domain is watched here
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // A taken word is one pulse, and words come no closer than the link allows
    AST_PULSE_SINGLE: assert property (update_pulse |=> !update_pulse [*3])
        else $error("update pulse too long or too close");
    // The output register moves only when a word is taken
    AST_CODE_ON_PULSE: assert property ($changed(output_code) |-> update_pulse)
        else $error("output code changed without a word");
    // Level is the code with its sign flipped
    AST_LEVEL_MAP: assert property (analog_output.level == {~output_code[9], output_code[8:0]})
        else $error("level does not follow code");
    // A new word starts the settling time
    AST_SETTLE_ON_PULSE: assert property (update_pulse |-> status.settling)
        else $error("no settling after word");
    // While awake, the settle timer keeps the output marked as moving after a word
    AST_SETTLE_HOLD: assert property (update_pulse && !status.asleep |=> status.settling [*8])
        else $error("settling dropped too early");
    // With select held high no word can be taken
    AST_IDLE_NO_PULSE: assert property (load_select_n [*8] |-> !update_pulse)
        else $error("word taken while deselected");
    // Held power-down puts the part to sleep
    AST_SLEEP_ENTRY: assert property (power_down [*4] |-> status.asleep && !analog_output.enable)
        else $error("sleep not entered");
    // Held power-down low keeps the part running
    AST_WAKE: assert property (!power_down [*6] |-> analog_output.enable && reference_output && !status.asleep)
        else $error("part not running");
    // Asleep means both stages are off
    AST_SLEEP_OFF: assert property (status.asleep |-> !analog_output.enable && !reference_output)
        else $error("stage powered while asleep");
endmodule // serial_dac_word_loader_props

bind serial_dac_word_loader serial_dac_word_loader_props u_serial_dac_word_loader_props (
    .core_clk, .rst_n, .load_select_n, .power_down, .output_code,
    .analog_output, .reference_output, .update_pulse, .status);

// ==== serial_dac_word_loader_tb_top.sv ====
/*
 * Self-checking bench of the serial converter word loader.
 * Assumes the package, design, checker and host model are compiled first.
 */
`timescale 1ns/1ps
module serial_dac_word_loader_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_down = 1'b0;
    logic shift_clk;
    logic load_select_n;
    logic serial_data;
    logic [9:0] output_code;
    dac_loader_pkg::dac_drive_t analog_output;
    logic reference_output;
    logic update_pulse;
    dac_loader_pkg::dac_status_t status;
    int failures = 0;
    int checks = 0;
    int pulses = 0;
    logic [31:0] seed = 32'h0000004B;
    logic [9:0] corner [6] = '{10'h1FF, 10'h200, 10'h3FF, 10'h000, 10'h001, 10'h155};

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    // Counts words taken
    always @(posedge core_clk) if (update_pulse === 1'b1) pulses <= pulses + 1;

    serial_dac_word_loader u_serial_dac_word_loader (
        .core_clk(core_clk), .rst_n(rst_n), .shift_clk(shift_clk), .load_select_n(load_select_n),
        .serial_data(serial_data), .power_down(power_down), .output_code(output_code),
        .analog_output(analog_output), .reference_output(reference_output),
        .update_pulse(update_pulse), .status(status));

    host_link_model u_host_link_model (
        .shift_clk(shift_clk), .load_select_n(load_select_n), .serial_data(serial_data));

    // Xorshift source
    function automatic logic [9:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[9:0];
    endfunction

    // Expected level: sign bit flipped
    function automatic logic [9:0] exp_level(input logic [9:0] code);
        return {~code[9], code[8:0]};
    endfunction

    // Compares and counts
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Sends a frame and checks the words taken and the held code
    task automatic frame(input logic [19:0] bits, input int n, input logic [9:0] exp, input int np);
        int base;
        base = pulses;
        u_host_link_model.send(bits, n);
        repeat (8) @(posedge core_clk);
        check(10'(pulses - base), 10'(np));
        check(output_code, exp);
        check(analog_output.level, exp_level(exp));
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog
    initial begin
        #400000;
        failures++;
        give_verdict();
    end

    initial begin
        logic [9:0] w;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(analog_output.level, 10'h200);
        // Corner codes then random ones
        for (int k = 0; k < 16; k++) begin
            w = (k < 6) ? corner[k] : next_rand();
            frame({10'h000, w}, 10, w, 1);
        end
        // Extra edges and a second word under one selection
        w = next_rand();
        frame({~w, w}, 20, w, 1);
        // Early release at 7 and at 9 bits
        frame({10'h000, ~w}, 7, w, 0);
        frame({10'h000, ~w}, 9, w, 0);
        // Sleep, a word taken while asleep, then wake
        @(posedge core_clk);
        power_down <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(10'({analog_output.enable, reference_output, status.asleep}), 10'h001);
        w = next_rand();
        frame({10'h000, w}, 10, w, 1);
        power_down <= 1'b0;
        repeat (6) @(posedge core_clk);
        check(10'({analog_output.enable, reference_output, status.asleep, status.settling}), 10'h00D);
        // Chip reset in mid-run returns the output to mid scale, then a word loads again
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(output_code, 10'h000);
        check(analog_output.level, 10'h200);
        w = next_rand();
        frame({10'h000, w}, 10, w, 1);
        give_verdict();
    end
endmodule // serial_dac_word_loader_tb_top
